/* rtl/irv_regs.svh */
// Constants of the index vector register: encodings, field positions,
// widths and scoreboard sizing.
// Assumes inclusion by bare name from package and design files alike.
`ifndef IRV_REGS_SVH
`define IRV_REGS_SVH

// ============================================================
// Register-number decode
`define IRV_REGTYPE_IDX     4'h1
`define IRV_REGISTER_NUMBER_FIELD_IDX      4'h0

// ============================================================
// Geometry
`define IRV_ELEMS           8
`define IRV_ELEM_W          16
`define IRV_IDX_W           12
`define IRV_FULL_ELEMS      3'h2
`define IRV_SPAN_BYTES      6'h10
`define IRV_SUBREG_LAST     5'h0e

// ============================================================
// Descriptor halves inside the first dword
`define IRV_DESC_LO_POS     0
`define IRV_DESC_HI_POS     16

// ============================================================
// Scoreboard sizing: depth of outstanding writes counted
`define IRV_SB_CNT_W        3
`define IRV_SB_CNT_ZERO     3'h0
`define IRV_SB_CNT_ONE      3'h1
`define IRV_SB_CNT_MAX      3'h7

`endif

/* rtl/irv_pkg.sv */
// Types shared by the index vector register and its write slice.
// Assumes the constants header sits next to this file.
`include "irv_regs.svh"

package irv_pkg;

  // Operand descriptor from decode, byte-granular within the register
  typedef struct packed {
    logic [7:0] reg_num;   // register_number_field
    logic [4:0] sub_num;   // subregister_number_field, bytes
    logic [4:0] nbytes;    // bytes spanned minus one
  } irv_opnd_t;

  // Write request from the retire side
  typedef struct packed {
    irv_opnd_t   opnd;
    logic [15:0] wmask;    // byte write mask across the 128-bit span
    logic [127:0] data;    // byte-aligned write data
  } irv_wr_t;

  typedef enum logic [1:0] {
    IRV_SB_IDLE = 2'b00,
    IRV_SB_BUSY = 2'b01
  } irv_sb_state_t;

endpackage

/* rtl/irv_elem.sv */
// One element of the index vector register: 16-bit word with an option
// to read back only the low 12 bits.
// Assumes byte enables already decoded by the parent.
`timescale 1ns/1ns
`default_nettype none
`include "irv_regs.svh"

module irv_elem
  import irv_pkg::*;
#(
  parameter bit FULL = 1'b1
) (
  input  wire logic        i_clk_sys,
  input  wire logic [1:0]  i_byte_we,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_rdata
);

  logic [15:0] store_r;

  // ============================================================
  // Storage, no reset: contents are undefined until written
  always_ff @(posedge i_clk_sys) begin
    if (i_byte_we[0]) begin
      store_r[7:0] <= i_wdata[7:0];
    end
    if (i_byte_we[1]) begin
      store_r[15:8] <= i_wdata[15:8];
    end
  end

  // ============================================================
  // Narrow elements store the top nibble on write but read zero there
  generate
    if (FULL) begin : g_full
      assign o_rdata = store_r;
    end else begin : g_narrow
      assign o_rdata = {4'h0, store_r[11:0]};
    end
  endgenerate

endmodule
`default_nettype wire

/* rtl/irv_top.sv */
// Index vector register of an execution unit: eight word elements used as
// operand, register-indirect row index and message descriptor source.
// Assumes decode supplies operand descriptors and retires writes in order;
// one clock, asynchronous active-low reset for the scoreboard and output registers, not storage.
//
// Summary of operation
// - Eight 16-bit elements form one vector
// - Selected by type 0001, number 0000 only
// - Indirect index uses word-aligned offsets 0..14
// - Explicit operands any type within 128 bits
// - Two elements per dword, even low half
// - Indirect index read as 12-bit unsigned
// - Elements 0,1 form 32-bit message descriptor
// - Elements 0,1 keep all 16 bits
// - Elements 2..7 store upper nibble on write
// - Elements 2..7 read zero upper nibble
// - Outstanding write stalls other writers unless they skip the check and fewer than 7 writes are counted
// - Outstanding write stalls other readers
// - Unpopulated writes dropped, reads unpredictable
`timescale 1ns/1ns
`default_nettype none
`include "irv_regs.svh"

module irv_top
  import irv_pkg::*;
(
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  // Issue side: an instruction asks to use the register
  input  wire logic         i_iss_valid,
  input  wire logic         i_iss_rd,
  input  wire logic         i_iss_wr,
  input  wire irv_opnd_t    i_iss_opnd,
  input  wire logic         i_skip_dest_dependency_check,
  input  wire logic         i_skip_dest_dependency_clear,
  output logic              o_iss_stall,
  // Retire side: write data arrives, clearing the scoreboard
  input  wire logic         i_wr_valid,
  input  wire irv_wr_t      i_wr,
  input  wire logic         i_wr_clr,
  // Read port for explicit source operands
  input  wire irv_opnd_t    i_rd_opnd,
  output logic      [127:0] o_rd_data,
  output logic              o_rd_hit,
  // Register-indirect index lookup
  input  wire logic   [4:0] i_idx_sub,
  output logic       [11:0] o_idx_row,
  output logic              o_idx_ok,
  // Message descriptor for send
  output logic       [31:0] o_desc,
  output logic              o_sb_busy
);

  // All checks below share the system clock and sleep through reset;
  // storage itself is never reset, so checks wait for i_nrst to stand.
  default clocking cb_sys @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);

  // ============================================================
  // Helpers
  // Register select: type nibble and register number both match
  function automatic logic sel_hit(input logic [7:0] rn);
    sel_hit = (rn[7:4] == `IRV_REGTYPE_IDX) &&
              (rn[3:0] == `IRV_REGISTER_NUMBER_FIELD_IDX);
  endfunction

  // Region must stay inside the 128-bit span
  function automatic logic in_span(input irv_opnd_t op);
    logic [5:0] last;
    last = {1'b0, op.sub_num} + {1'b0, op.nbytes};
    in_span = (last < `IRV_SPAN_BYTES);
  endfunction

  // Byte mask covered by an operand region
  function automatic logic [15:0] span_mask(input irv_opnd_t op);
    logic [15:0] m;
    m = '0;
    for (int b = 0; b < 16; b++) begin
      if ((5'(b) >= op.sub_num) && (5'(b) <= op.sub_num + op.nbytes)) begin
        m[b] = 1'b1;
      end
    end
    span_mask = m;
  endfunction

  // ============================================================
  // Element storage
  logic [15:0] elem_rd [`IRV_ELEMS];
  logic [15:0] wr_be;
  logic        wr_ok;
  logic [127:0] vec;

  // Writes outside the register or its span are dropped silently
  assign wr_ok = i_wr_valid && sel_hit(i_wr.opnd.reg_num) &&
                 in_span(i_wr.opnd);
  assign wr_be = wr_ok ? (i_wr.wmask & span_mask(i_wr.opnd)) : 16'h0000;

  generate
    for (genvar e = 0; e < `IRV_ELEMS; e++) begin : g_elem
      irv_elem #(
        .FULL (e < 2)
      ) u_elem (
        .i_clk_sys (i_clk_sys),
        .i_byte_we (wr_be[2*e+1 -: 2]),
        .i_wdata   (i_wr.data[16*e+15 -: 16]),
        .o_rdata   (elem_rd[e])
      );
      assign vec[16*e+15 -: 16] = elem_rd[e];
    end
  endgenerate

  // ============================================================
  // Explicit source read: whole span shifted to the addressed byte
  logic rd_ok;
  assign rd_ok = sel_hit(i_rd_opnd.reg_num) && in_span(i_rd_opnd);

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rd_data <= 128'h0;
      o_rd_hit  <= 1'b0;
    end else begin
      o_rd_data <= vec >> {i_rd_opnd.sub_num[3:0], 3'h0};
      o_rd_hit  <= rd_ok;
    end
  end

  // ============================================================
  // Register-indirect index: word-aligned offsets only, 12 bits used
  logic [2:0] idx_el;
  logic       idx_legal;
  logic [15:0] idx_word;
  assign idx_el    = i_idx_sub[3:1];
  assign idx_legal = !i_idx_sub[0] &&
                     (i_idx_sub <= `IRV_SUBREG_LAST);
  assign idx_word  = elem_rd[idx_el];

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_idx_row <= 12'h000;
      o_idx_ok  <= 1'b0;
    end else begin
      o_idx_row <= idx_legal ? idx_word[11:0] : 12'h000;
      o_idx_ok  <= idx_legal;
    end
  end

  // ============================================================
  // Message descriptor from the first dword, element 1 on top
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_desc <= 32'h0;
    end else begin
      o_desc[`IRV_DESC_LO_POS +: 16] <= elem_rd[0];
      o_desc[`IRV_DESC_HI_POS +: 16] <= elem_rd[1];
    end
  end

  // ============================================================
  // Single scoreboard for the whole register. A count of outstanding
  // writes lets back-to-back writers under the skip controls pile up
  // without losing track of the last retirement.
  logic [`IRV_SB_CNT_W-1:0] sb_cnt_r;
  logic [`IRV_SB_CNT_W-1:0] sb_cnt_nxt;
  logic iss_hit;
  logic iss_take;
  logic sb_set;
  logic sb_clr;
  logic sb_busy;

  assign sb_busy  = (sb_cnt_r != `IRV_SB_CNT_ZERO);
  assign iss_hit  = i_iss_valid && sel_hit(i_iss_opnd.reg_num);

  // Any reader or writer waits while a write is in flight, unless the
  // writer asks to skip the check; a full counter also holds writers
  always_comb begin
    o_iss_stall = 1'b0;
    if (iss_hit && sb_busy) begin
      if (i_iss_rd) begin
        o_iss_stall = 1'b1;
      end
      if (i_iss_wr && !i_skip_dest_dependency_check) begin
        o_iss_stall = 1'b1;
      end
    end
    if (iss_hit && i_iss_wr && (sb_cnt_r == `IRV_SB_CNT_MAX)) begin
      o_iss_stall = 1'b1;
    end
  end

  assign iss_take = iss_hit && !o_iss_stall;
  // A writer issued with the skip-clear control leaves no scoreboard mark
  assign sb_set = iss_take && i_iss_wr && !i_skip_dest_dependency_clear;
  assign sb_clr = i_wr_clr && sb_busy;

  always_comb begin
    sb_cnt_nxt = sb_cnt_r;
    if (sb_set && !sb_clr) begin
      sb_cnt_nxt = sb_cnt_r + `IRV_SB_CNT_ONE;
    end else if (sb_clr && !sb_set) begin
      sb_cnt_nxt = sb_cnt_r - `IRV_SB_CNT_ONE;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sb_cnt_r <= `IRV_SB_CNT_ZERO;
    end else begin
      sb_cnt_r <= sb_cnt_nxt;
    end
  end

  assign o_sb_busy = sb_busy;

  // ============================================================
  // Checks: clock and reset come from the defaults at the top
  chk_rd_stall: assert property
    ((iss_hit && i_iss_rd && sb_busy) |-> o_iss_stall)
    else $error("reader issued while register write outstanding");

  chk_wr_stall: assert property
    ((iss_hit && i_iss_wr && sb_busy && !i_skip_dest_dependency_check)
      |-> o_iss_stall)
    else $error("writer issued while register write outstanding");

  chk_sb_idle_free: assert property
    ((!sb_busy && iss_hit && !i_iss_wr) |-> !o_iss_stall)
    else $error("stall raised with scoreboard idle");

  chk_sb_count: assert property
    ((sb_set && !sb_clr && sb_cnt_r == `IRV_SB_CNT_ZERO) |=> sb_busy)
    else $error("scoreboard not set by issued writer");

  // A lost decrement would hold every later reader forever
  chk_sb_drain: assert property
    ((sb_clr && !sb_set && sb_cnt_r == `IRV_SB_CNT_ONE) |=> !sb_busy)
    else $error("scoreboard still busy after last retirement");

  chk_skip_pass: assert property
    ((iss_hit && i_iss_wr && !i_iss_rd && i_skip_dest_dependency_check &&
      sb_cnt_r != `IRV_SB_CNT_MAX) |-> !o_iss_stall)
    else $error("writer with skip-check stalled");

  chk_skip_nomark: assert property
    ((iss_take && i_iss_wr && i_skip_dest_dependency_clear && !sb_clr)
      |=> (sb_cnt_r == $past(sb_cnt_r)))
    else $error("writer with skip-clear marked the scoreboard");

  chk_narrow_top: assert property
    ((vec[127:32] & {6{16'hf000}}) == 96'h0)
    else $error("narrow element shows upper nibble");

  chk_full_keep: assert property
    ((wr_be[1:0] == 2'b11) |=> (elem_rd[0] == $past(i_wr.data[15:0])))
    else $error("element 0 lost bits on write");

  chk_narrow_drop: assert property
    ((wr_be[5:4] == 2'b11) |=>
      (elem_rd[2] == {4'h0, $past(i_wr.data[43:32])}))
    else $error("element 2 kept upper nibble");

  chk_drop_span: assert property
    ((i_wr_valid && !in_span(i_wr.opnd)) |-> (wr_be == 16'h0000))
    else $error("write beyond the register span enabled");

  // Registered outputs still show reset at the first edge after release
  chk_desc_pair: assert property
    (i_nrst |=> (o_desc == {$past(elem_rd[1]), $past(elem_rd[0])}))
    else $error("descriptor does not follow elements 0 and 1");

  chk_rd_shift: assert property
    ((i_nrst && rd_ok) |=> (o_rd_hit && o_rd_data ==
      ($past(vec) >> {$past(i_rd_opnd.sub_num[3:0]), 3'h0})))
    else $error("read data not shifted to the addressed byte");

  chk_rd_miss: assert property
    (!rd_ok |=> !o_rd_hit)
    else $error("read hit on another register or out of span");

  chk_idx_row: assert property
    ((i_nrst && idx_legal) |=>
      (o_idx_ok && o_idx_row == $past(idx_word[11:0])))
    else $error("index row not the low 12 bits");

  chk_idx_bad_row: assert property
    (!idx_legal |=> (o_idx_row == 12'h000))
    else $error("illegal index offset gave a nonzero row");

  chk_idx_legal: assert property
    (i_idx_sub[0] |=> !o_idx_ok)
    else $error("odd index offset accepted");

  chk_sel: assert property
    ((i_wr_valid && i_wr.opnd.reg_num[7:4] != 4'h1) |-> (wr_be == 16'h0))
    else $error("write accepted for another register type");

endmodule
`default_nettype wire

/* sim/irv_partner.sv */
// Partner model: issue and retire logic beside the index vector register.
// Assumes the bench commands it; one clock, async active-low reset.
`timescale 1ns/1ns
`default_nettype none

module irv_partner
  import irv_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic       i_go,
  input  wire logic [3:0] i_cmd,
  input  wire irv_opnd_t  i_opnd,
  input  wire logic [5:0] i_lat,
  input  wire logic       i_stall,
  output logic            o_valid,
  output logic      [3:0] o_cmd,
  output irv_opnd_t       o_opnd,
  output logic            o_wr_clr
);
  logic [5:0] cnt_r;
  // =======
  // Issue: held while stalled; cmd is {read, write, skip chk, skip clr}
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_valid <= 1'b0;
      o_cmd   <= 4'h0;
      o_opnd  <= '0;
    end else if (i_go) begin
      o_valid <= 1'b1;
      o_cmd   <= i_cmd;
      o_opnd  <= i_opnd;
    end else if (!i_stall) begin
      o_valid <= 1'b0;
    end
  end
  // =======
  // Retire: one marked write at a time, cleared i_lat cycles after issue
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_r    <= 6'h00;
      o_wr_clr <= 1'b0;
    end else begin
      o_wr_clr <= (cnt_r == 6'h01);
      if (o_valid && !i_stall && o_cmd[2] && !o_cmd[0]) begin
        cnt_r <= i_lat;
      end else if (cnt_r != 6'h00) begin
        cnt_r <= cnt_r - 6'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/test_irv_top.sv */
// Bench for the index vector register: data, index and stall checks.
// Assumes the partner model plays the issue and retire logic.
`timescale 1ns/1ns
`default_nettype none

module test_irv_top;
  import irv_pkg::*;
  typedef struct packed {
    logic dchk; logic [127:0] data; logic hit;
    logic [11:0] row; logic ok; logic [31:0] desc;
  } irv_note_t;
  logic         i_clk_sys = 1'b0, i_nrst = 1'b1, i_wr_valid = 1'b0;
  logic         go = 1'b0, pv = 1'b0, pv_d = 1'b0, sv = 1'b0;
  logic [3:0]   cmd = 4'h0, iss_cmd;
  logic [5:0]   lat = 6'h19;
  logic [4:0]   idx_sub = 5'h00;
  logic [11:0]  idx_row;
  logic [15:0]  w, sh [8];
  logic [31:0]  desc, rs = 32'h00007f2e;
  logic [127:0] rd_data;
  logic [1:0]   st, sq [$];
  logic         iss_valid, stall, wr_clr, rd_hit, idx_ok, busy;
  irv_opnd_t    opnd = '0, rd_opnd = '0, iss_opnd;
  irv_wr_t      wr = '0;
  irv_note_t    nt, nq [$];
  int           num_errors = 0, n_compared = 0;

  // Clock at 125 MHz
  always #4 i_clk_sys = ~i_clk_sys;

  irv_top irv_top_i (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_iss_valid(iss_valid), .i_iss_rd(iss_cmd[3]), .i_iss_wr(iss_cmd[2]),
    .i_iss_opnd(iss_opnd), .i_skip_dest_dependency_check(iss_cmd[1]),
    .i_skip_dest_dependency_clear(iss_cmd[0]), .o_iss_stall(stall),
    .i_wr_valid(i_wr_valid), .i_wr(wr), .i_wr_clr(wr_clr),
    .i_rd_opnd(rd_opnd), .o_rd_data(rd_data), .o_rd_hit(rd_hit),
    .i_idx_sub(idx_sub), .o_idx_row(idx_row), .o_idx_ok(idx_ok),
    .o_desc(desc), .o_sb_busy(busy));
  irv_partner irv_partner_i (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_go(go), .i_cmd(cmd), .i_opnd(opnd), .i_lat(lat), .i_stall(stall),
    .o_valid(iss_valid), .o_cmd(iss_cmd), .o_opnd(iss_opnd),
    .o_wr_clr(wr_clr));

  // =======
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic cmp_v(input logic [127:0] g, input logic [127:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_b(input logic g, input logic e);
    cmp_v(128'(g), 128'(e));
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Retire-side write of one region; whole struct held for one edge
  task automatic wr_el(input logic [7:0] r, input logic [4:0] s,
    input logic [4:0] n, input logic [127:0] d, input logic [15:0] m);
    @(posedge i_clk_sys);
    i_wr_valid <= 1'b1;
    wr <= '{'{r, s, n}, m, d};
    @(posedge i_clk_sys);
    i_wr_valid <= 1'b0;
  endtask
  // Read and index request; expectation worked out from the shadow copy
  task automatic probe(input irv_opnd_t o, input logic [2:0] e,
    input logic b, input logic dc, input logic h);
    irv_note_t n;
    for (int i = 0; i < 8; i++) n.data[16*i +: 16] = sh[i];
    n.data = n.data >> (8 * o.sub_num[3:0]);
    n.dchk = dc;
    n.hit  = h & i_nrst;
    n.ok   = !b & i_nrst;
    n.row  = n.ok ? sh[e][11:0] : 12'h000;
    n.desc = i_nrst ? {sh[1], sh[0]} : 32'h0;
    @(posedge i_clk_sys);
    rd_opnd <= o;
    idx_sub <= {1'b0, e, b};
    pv <= 1'b1;
    nq.push_back(n);
    @(posedge i_clk_sys);
    pv <= 1'b0;
  endtask
  // Issue through the partner; stall and busy expected while it is up
  task automatic issue(input logic [3:0] c, input logic [7:0] r,
    input logic [1:0] ex);
    @(posedge i_clk_sys);
    go <= 1'b1;
    cmd <= c;
    opnd <= '{r, 5'h00, 5'h01};
    @(posedge i_clk_sys);
    go <= 1'b0;
    sv <= 1'b1;
    sq.push_back(ex);
    @(posedge i_clk_sys);
    sv <= 1'b0;
  endtask
  // Bounded wait for the scoreboard to drain
  // Busy is looked at on the falling edge, where it has settled
  task automatic wait_idle();
    @(negedge i_clk_sys);
    for (int k = 0; busy !== 1'b0; k++) begin
      if (k == 60) begin
        num_errors++;
        $display("mismatch at %0t: busy %h expected %h", $time, busy, 1'b0);
        finish_test();
      end
      @(negedge i_clk_sys);
    end
  endtask

  // =======
  // Monitor: oldest note against the settled outputs
  always @(posedge i_clk_sys) pv_d <= pv;
  always @(negedge i_clk_sys) begin
    if (pv_d) begin
      nt = nq.pop_front();
      if (nt.dchk) cmp_v(rd_data, nt.data);
      cmp_b(rd_hit, nt.hit);
      cmp_v(128'(idx_row), 128'(nt.row));
      cmp_b(idx_ok, nt.ok);
      cmp_v(128'(desc), 128'(nt.desc));
    end
    if (sv) begin
      st = sq.pop_front();
      cmp_b(stall, st[1]);
      cmp_b(busy, st[0]);
    end
  end

  // =======
  // Main sequence
  initial begin
    #1 i_nrst = 1'b0;
    // Storage has no reset: fill it early so every check sees known data
    rs = xs(rs);
    @(posedge i_clk_sys);
    wr_el(8'h10, 5'h00, 5'h0f, {4{rs}}, 16'hffff);
    for (int e = 0; e < 8; e++) begin
      sh[e] = rs[16*(e%2) +: 16];
      if (e > 1) sh[e][15:12] = 4'h0;
    end
    probe('{8'h10, 5'h00, 5'h0f}, 3'h0, 1'b0, 1'b0, 1'b0);
    issue(4'h4, 8'h10, 2'b00);
    repeat (4) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    $display("reset test done");
    // Top bit always set, so narrow elements must drop it
    for (int e = 0; e < 8; e++) begin
      rs = xs(rs);
      w = rs[15:0] | 16'h8000;
      wr_el(8'h10, 5'(2*e), 5'h01, 128'(w) << (16*e), 16'h0003 << (2*e));
      sh[e] = (e < 2) ? w : {4'h0, w[11:0]};
    end
    probe('{8'h10, 5'h00, 5'h0f}, 3'h0, 1'b0, 1'b1, 1'b1);
    // Each element read at its word offset, then odd index offsets and out-of-span reads rejected
    for (int e = 0; e < 8; e++) begin
      probe('{8'h10, 5'(2*e), 5'h01}, 3'(e), 1'b0, 1'b1, 1'b1);
      probe('{(e%2) ? 8'h10 : 8'h11, 5'h0e, 5'h03}, 3'(e), 1'b1, 1'b0, 1'b0);
    end
    // Dropped writes, then a dword write over elements 2 and 3
    wr_el(8'h11, 5'h00, 5'h03, '1, 16'h000f);
    wr_el(8'h10, 5'h0e, 5'h03, '1, 16'hc000);
    rs = xs(rs);
    wr_el(8'h10, 5'h04, 5'h03, {64'h0, rs, 32'h0}, 16'h00f0);
    sh[2] = {4'h0, rs[11:0]};
    sh[3] = {4'h0, rs[27:16]};
    probe('{8'h10, 5'h04, 5'h03}, 3'h3, 1'b0, 1'b1, 1'b1);
    probe('{8'h10, 5'h00, 5'h0f}, 3'h2, 1'b0, 1'b1, 1'b1);
    $display("data test done");
    // Slow retire: others wait unless they skip the check
    issue(4'h4, 8'h10, 2'b00);
    issue(4'h8, 8'h10, 2'b11);
    issue(4'h4, 8'h10, 2'b11);
    issue(4'h8, 8'h20, 2'b01);
    issue(4'h7, 8'h10, 2'b01);
    wait_idle();
    issue(4'h8, 8'h10, 2'b00);
    lat <= 6'h03;
    issue(4'h4, 8'h10, 2'b00);
    issue(4'h8, 8'h10, 2'b11);
    wait_idle();
    $display("scoreboard test done");
    finish_test();
  end
endmodule
`default_nettype wire
